// ### hdl/vectored_irq_defs.vh
// Register offsets, field positions and reset values of the vectored interrupt unit
`ifndef VECTORED_IRQ_DEFS_VH
`define VECTORED_IRQ_DEFS_VH
`define VIU_BASE_ADDR      32'hfffff000
`define VIU_WINDOW_MASK    32'hfffff000
`define VIU_OFF_MODE_LAST  12'h07c
`define VIU_OFF_HADDR_LO   12'h080
`define VIU_OFF_HADDR_HI   12'h0fc
`define VIU_OFF_NVEC       12'h100
`define VIU_OFF_FVEC       12'h104
`define VIU_OFF_CURID      12'h108
`define VIU_OFF_PEND       12'h10c
`define VIU_OFF_ENAB       12'h110
`define VIU_OFF_CORE       12'h114
`define VIU_OFF_ENCMD      12'h120
`define VIU_OFF_DISCMD     12'h124
`define VIU_OFF_CLRCMD     12'h128
`define VIU_OFF_SETCMD     12'h12c
`define VIU_OFF_EOS        12'h130
`define VIU_OFF_SPUR       12'h134
`define VIU_OFF_DBG        12'h138
`define VIU_OFF_FFEN       12'h140
`define VIU_OFF_FFDIS      12'h144
`define VIU_OFF_FFSTATE    12'h148
`define VIU_PRIO_LSB       0
`define VIU_PRIO_MSB       2
`define VIU_TYPE_EDGE_BIT  5
`define VIU_MODE_MASK      32'h00000067
`define VIU_DBG_PROTECT    0
`define VIU_DBG_GMASK      1
`define VIU_DBG_MASK       32'h00000003
`define VIU_RESET_WORD     32'h00000000
`define VIU_EXT_MASK       32'hf0000000
`endif

// ### hdl/vectored_irq_unit.v
// Vectored interrupt unit: 32 sources, vectoring, spurious protection and global mask
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
`include "vectored_irq_defs.vh"

module vectored_irq_unit
(
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        cyc_i,
   input  wire        stb_i,
   input  wire        we_i,
   input  wire [31:0] adr_i,
   input  wire [3:0]  sel_i,
   input  wire [31:0] dat_i,
   output reg  [31:0] dat_o,
   output reg         ack_o,
   input  wire [31:0] irq_src_i,
   output reg         normal_irq_n_o,
   output reg         fast_irq_n_o,
   output reg         wake_o
);

   reg  [31:0] source_mode [0:31];
   reg  [31:0] handler_address [0:31];
   reg  [31:0] spurious_handler_address;
   reg  [31:0] debug_control;
   reg  [31:0] pending_flags;
   reg  [31:0] enabled_flags;
   reg  [31:0] fast_redirect_state;
   reg  [31:0] src_prev;
   reg         boot;
   reg  [4:0]  cur_id;
   reg  [2:0]  level_stack [0:7];
   reg  [7:0]  stack_valid;
   reg  [3:0]  depth;
   reg  [31:0] next_pending;
   reg  [4:0]  best_id;
   reg  [2:0]  best_prio;
   reg         best_found;
   reg  [31:0] rd_word;
   integer     i;
   integer     j;
   integer     n;
   integer     p;

   wire        acc      = cyc_i & stb_i & ~ack_o;
   wire        in_win   = (adr_i & `VIU_WINDOW_MASK) == `VIU_BASE_ADDR;
   wire [11:0] off      = {adr_i[11:2], 2'b00};
   wire        wr       = acc & we_i & in_win;
   wire        rd       = acc & ~we_i & in_win;
   wire [4:0]  widx     = off[6:2];
   wire [31:0] active   = pending_flags & enabled_flags;
   wire [31:0] normal_c = active & ~fast_redirect_state & 32'hfffffffe;
   wire        fast_c   = active[0] | (|(active & fast_redirect_state));
   wire [2:0]  cur_lvl  = level_stack[depth[2:0] - 3'd1];
   wire        in_srv   = stack_valid[0];
   wire        gmask    = debug_control[`VIU_DBG_GMASK];
   wire        protect  = debug_control[`VIU_DBG_PROTECT];

   // Byte-lane merge of a write into an old word
   function [31:0] merge;
      input [31:0] old_w;
      input [31:0] new_w;
      input [3:0]  lanes;
      integer      b;
      begin
         merge = old_w;
         for (b = 0; b < 4; b = b + 1)
            if (lanes[b])
               merge[b*8 +: 8] = new_w[b*8 +: 8];
      end
   endfunction

   // Offset lies in the mode register bank
   function is_mode_off;
      input [11:0] o;
      begin
         is_mode_off = o <= `VIU_OFF_MODE_LAST;
      end
   endfunction

   // Offset lies in the handler address bank
   function is_haddr_off;
      input [11:0] o;
      begin
         is_haddr_off = (o >= `VIU_OFF_HADDR_LO) && (o <= `VIU_OFF_HADDR_HI);
      end
   endfunction

   // Priority field of a mode word
   function [2:0] prio_of;
      input [31:0] mw;
      begin
         prio_of = mw[`VIU_PRIO_MSB:`VIU_PRIO_LSB];
      end
   endfunction

   // Edge-triggered flag of a mode word
   function edge_of;
      input [31:0] mw;
      begin
         edge_of = mw[`VIU_TYPE_EDGE_BIT];
      end
   endfunction

   // Pick the highest-priority normal candidate above the current level;
   // lower numbers win ties, as only a strictly higher level replaces
   always @*
   begin
      best_id    = 5'h00;
      best_prio  = 3'h0;
      best_found = 1'b0;
      // Source 0 is the fast source and never competes here
      for (i = 1; i < 32; i = i + 1)
      begin
         if (normal_c[i] && (!best_found || prio_of(source_mode[i]) > best_prio)
             && (!in_srv || prio_of(source_mode[i]) > cur_lvl))
         begin
            best_found = 1'b1;
            best_id    = i[4:0];
            best_prio  = prio_of(source_mode[i]);
         end
      end
   end

   // Read multiplexer; reserved and write-only offsets read zero
   always @*
   begin
      rd_word = `VIU_RESET_WORD;
      if (is_mode_off(off))
         rd_word = source_mode[widx];
      else if (is_haddr_off(off))
         rd_word = handler_address[widx];
      else
         case (off)
            `VIU_OFF_NVEC:    rd_word = best_found ? handler_address[best_id] : spurious_handler_address;
            `VIU_OFF_FVEC:    rd_word = fast_c ? handler_address[0] : spurious_handler_address;
            // source recorded by the last fetch that pushed the stack
            `VIU_OFF_CURID:   rd_word = {27'h0000000, cur_id};
            `VIU_OFF_PEND:    rd_word = pending_flags;
            // Enabled sources
            `VIU_OFF_ENAB:    rd_word = enabled_flags;
            // Line state as the core sees it, active high here
            `VIU_OFF_CORE:    rd_word = {30'h00000000, ~normal_irq_n_o, ~fast_irq_n_o};
            `VIU_OFF_SPUR:    rd_word = spurious_handler_address;
            // Protect and global mask bits only
            `VIU_OFF_DBG:     rd_word = debug_control;
            `VIU_OFF_FFSTATE: rd_word = fast_redirect_state;
            // write-only command words read as zero
            `VIU_OFF_ENCMD,
            `VIU_OFF_DISCMD,
            `VIU_OFF_CLRCMD,
            `VIU_OFF_SETCMD,
            `VIU_OFF_EOS,
            `VIU_OFF_FFEN,
            `VIU_OFF_FFDIS:   rd_word = `VIU_RESET_WORD;
            default:          rd_word = `VIU_RESET_WORD;
         endcase
   end

   // Decoded strobes shared by the pending logic, the banks and the stack
   wire        nvec_hit = off == `VIU_OFF_NVEC;
   wire        wr_mode  = wr & is_mode_off(off);
   wire        wr_haddr = wr & is_haddr_off(off);
   wire        wr_set   = wr & (off == `VIU_OFF_SETCMD);
   wire        wr_eos   = wr & (off == `VIU_OFF_EOS);
   // a fetch is a read in normal mode, a write in protect mode
   wire        fetch    = best_found & nvec_hit & ((rd & ~protect) | (wr & protect));
   // Pushes past eight levels are dropped; the read still answers
   wire        push     = fetch & (depth < 4'd8);
   wire        pop      = wr_eos & in_srv;
   // Fetches clear an edge source; a level source stays until its input drops
   wire        ack_fast = rd & (off == `VIU_OFF_FVEC) & edge_of(source_mode[0]);
   wire        ack_norm = fetch & edge_of(source_mode[best_id]);

   // Pending capture: edges latch, levels follow, hardware set beats clear
   always @*
   begin
      next_pending = pending_flags;
      // Software clear first, so a same-cycle edge still wins below
      if (wr && off == `VIU_OFF_CLRCMD)
      begin
         next_pending = next_pending & ~dat_i;
      end
      // Acknowledge of an edge source on a fast vector read
      if (ack_fast)
      begin
         next_pending[0] = 1'b0;
      end
      // Acknowledge of the fetched edge source on a normal fetch
      if (ack_norm)
      begin
         next_pending[best_id] = 1'b0;
      end
      if (wr_set)
      begin
         next_pending = next_pending | dat_i;
      end
      for (p = 0; p < 32; p = p + 1)
      begin
         // level or edge by type low bit
         if (edge_of(source_mode[p]))
         begin
            if (irq_src_i[p] & ~src_prev[p])
               next_pending[p] = 1'b1;
         end
         else if (!(wr_set && dat_i[p]))
         begin
            next_pending[p] = irq_src_i[p];
         end
      end
   end

   // Start-up flag and previous source levels for edge detection
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         boot     <= 1'b1;
         src_prev <= `VIU_RESET_WORD;
      end
      else
      begin
         boot     <= 1'b0;
         src_prev <= irq_src_i;
      end
   end

   // first cycle after reset shows external levels only
   always @(posedge clk_i)
   begin
      if (rst_i)
         pending_flags <= `VIU_RESET_WORD;
      else if (boot)
         pending_flags <= irq_src_i & `VIU_EXT_MASK;
      else
         pending_flags <= next_pending;
   end

   // banks reset to zero; writes merge byte lanes
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         for (j = 0; j < 32; j = j + 1)
         begin
            source_mode[j]     <= `VIU_RESET_WORD;
            handler_address[j] <= `VIU_RESET_WORD;
         end
      end
      else if (wr_mode)
         // only priority and type bits are kept
         source_mode[widx] <= merge(source_mode[widx], dat_i, sel_i) & `VIU_MODE_MASK;
      else if (wr_haddr)
         handler_address[widx] <= merge(handler_address[widx], dat_i, sel_i);
   end

   // Software-held words and command registers; reserved offsets ignored
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         spurious_handler_address <= `VIU_RESET_WORD;
         debug_control            <= `VIU_RESET_WORD;
         enabled_flags            <= `VIU_RESET_WORD;
         fast_redirect_state      <= `VIU_RESET_WORD;
      end
      else if (wr)
         case (off)
            `VIU_OFF_ENCMD:  enabled_flags <= enabled_flags | dat_i;
            `VIU_OFF_DISCMD: enabled_flags <= enabled_flags & ~dat_i;
            `VIU_OFF_SPUR:   spurious_handler_address <= merge(spurious_handler_address, dat_i, sel_i);
            `VIU_OFF_DBG:    debug_control <= merge(debug_control, dat_i, sel_i) & `VIU_DBG_MASK;
            // redirect enable and disable; source 0 is always fast
            `VIU_OFF_FFEN:   fast_redirect_state <= fast_redirect_state | (dat_i & 32'hfffffffe);
            `VIU_OFF_FFDIS:  fast_redirect_state <= fast_redirect_state & ~dat_i;
            default: ;
         endcase
   end

   // service stack: push on fetch, pop on end of service
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         for (n = 0; n < 8; n = n + 1)
            level_stack[n] <= 3'h0;
         stack_valid <= 8'h00;
         depth       <= 4'h0;
         cur_id      <= 5'h00;
      end
      else if (push)
      begin
         level_stack[depth[2:0]] <= prio_of(source_mode[best_id]);
         stack_valid             <= {stack_valid[6:0], 1'b1};
         depth                   <= depth + 4'd1;
         cur_id                  <= best_id;
      end
      else if (pop)
      begin
         // data ignored, only the access counts
         stack_valid <= stack_valid >> 1;
         depth       <= depth - 4'd1;
      end
   end

   // One wait-free answer; any address answers, outside window reads zero
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_o <= 1'b0;
         dat_o <= `VIU_RESET_WORD;
      end
      else
      begin
         ack_o <= acc;
         dat_o <= rd ? rd_word : `VIU_RESET_WORD;
      end
   end

   // Request lines registered so the core never sees a decode glitch
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         normal_irq_n_o <= 1'b1;
         fast_irq_n_o   <= 1'b1;
         wake_o         <= 1'b0;
      end
      else
      begin
         normal_irq_n_o <= ~(best_found & ~gmask);
         fast_irq_n_o   <= ~(fast_c & ~gmask);
         wake_o         <= |active;
      end
   end

endmodule // vectored_irq_unit

// ### tb/irq_bus_checker.sv
// Checker for bus answers and request lines of the vectored interrupt unit
`timescale 1ns/1ps
module irq_bus_checker
(
   input wire        clk_i,
   input wire        rst_i,
   input wire        cyc_i,
   input wire        stb_i,
   input wire        we_i,
   input wire [31:0] adr_i,
   input wire [31:0] dat_i,
   input wire [31:0] dat_o,
   input wire        ack_o,
   input wire        normal_irq_n_o,
   input wire        fast_irq_n_o,
   input wire        wake_o
);
   reg         gm;
   wire        rdk = ack_o && cyc_i && !we_i;
   wire [11:0] off = adr_i[11:0];
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // Shadow of the global mask bit; byte lanes assumed full
   always @(posedge clk_i)
   begin
      if (rst_i)
         gm <= 1'b0;
      else if (ack_o && we_i && adr_i == 32'hfffff138)
         gm <= dat_i[1];
   end
   AST_ACK_ONE: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("late ack");
   AST_ACK_PULSE: assert property (ack_o |=> !ack_o) else $error("long ack");
   AST_GMASK: assert property (gm && $past(gm, 2) |-> normal_irq_n_o && fast_irq_n_o)
      else $error("line active while masked");
   AST_WAKE: assert property (!normal_irq_n_o || !fast_irq_n_o |-> wake_o)
      else $error("request without wake");
   AST_OUT_WIN: assert property (ack_o && cyc_i && adr_i[31:12] != 20'hfffff |-> dat_o == 32'h0)
      else $error("data outside window");
   AST_RSVD: assert property (rdk && (off == 12'h118 || off == 12'h11c || off == 12'h13c || off >= 12'h14c)
      |-> dat_o == 32'h0) else $error("reserved read not zero");
   AST_MODE: assert property (rdk && adr_i[31:7] == 25'h1ffffe0 |-> (dat_o & 32'hffffff98) == 32'h0)
      else $error("mode read has stray bits");
   AST_RESET: assert property (disable iff (1'b0) rst_i |=> !ack_o && !wake_o && normal_irq_n_o && fast_irq_n_o)
      else $error("outputs active after reset");
   COV_MASKED: cover property (gm && wake_o);
   COV_NORMAL: cover property (!normal_irq_n_o);
   COV_FAST: cover property (!fast_irq_n_o);
endmodule // irq_bus_checker

bind vectored_irq_unit irq_bus_checker i_irq_bus_checker
(
   .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
   .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .normal_irq_n_o(normal_irq_n_o),
   .fast_irq_n_o(fast_irq_n_o), .wake_o(wake_o)
);

// ### tb/core_model.sv
// Core model issuing classic single bus cycles toward the unit
`timescale 1ns/1ps
module core_model
(
   input  wire        clk_i,
   input  wire        ack_i,
   input  wire [31:0] dat_i,
   output reg         cyc_o = 1'b0,
   output reg         we_o = 1'b0,
   output reg  [31:0] adr_o = 32'h0,
   output reg  [31:0] dat_o = 32'h0
);
   // Request held until ack; released data shows its inverse
   task xfer(input w, input [31:0] a, input [31:0] wd, output [31:0] rd);
      begin
         @(posedge clk_i);
         cyc_o <= 1'b1;
         we_o  <= w;
         adr_o <= a;
         dat_o <= wd;
         @(posedge clk_i);
         while (ack_i !== 1'b1)
            @(posedge clk_i);
         rd = dat_i;
         cyc_o <= 1'b0;
         we_o  <= 1'b0;
         dat_o <= ~wd;
         @(posedge clk_i);
      end
   endtask
endmodule // core_model

// ### tb/tb_top.sv
// Self-checking bench for the vectored interrupt unit
`timescale 1ns/1ps
module tb_top;
   reg         clk_i = 1'b0;
   reg         rst_i = 1'b1;
   reg  [31:0] irq_src_i;
   wire        cyc, we, ack, normal_irq_n, fast_irq_n, wake;
   wire [31:0] adr, wdat, rdat;
   reg  [31:0] hv [0:31];
   reg  [31:0] spur, v, m;
   integer     stk [$];
   integer     err_count = 0, tests_run = 0, cycles = 0, seed = 32'hbe8dcb34, k;
   // 200 MHz clock
   always #2.5 clk_i = ~clk_i;
   vectored_irq_unit i_vectored_irq_unit
   (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(cyc), .we_i(we), .adr_i(adr),
      .sel_i(4'hf), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .irq_src_i(irq_src_i),
      .normal_irq_n_o(normal_irq_n), .fast_irq_n_o(fast_irq_n), .wake_o(wake)
   );
   core_model i_core_model
   (
      .clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .we_o(we), .adr_o(adr), .dat_o(wdat)
   );
   task chk(input string nm, input [31:0] e, input [31:0] g);
      begin
         tests_run = tests_run + 1;
         if (g !== e)
         begin
            err_count = err_count + 1;
            $display("Error %0s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task wr(input [11:0] o, input [31:0] d);
      i_core_model.xfer(1'b1, {20'hfffff, o}, d, v);
   endtask
   task rd(input [11:0] o, input [31:0] e);
      begin
         i_core_model.xfer(1'b0, {20'hfffff, o}, 32'h0, v);
         chk($sformatf("offset %h", o), e, v);
      end
   endtask
   // Two cycles of pipeline plus margin before looking at lines
   task settle;
      repeat (3) @(posedge clk_i);
   endtask
   task drive(input [31:0] s);
      begin
         @(posedge clk_i);
         irq_src_i <= s;
         settle;
      end
   endtask
   task wrap_up;
      begin
         $display("checks %0d mismatches %0d", tests_run, err_count);
         if (err_count == 0 && tests_run > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   // Ceiling well above the roughly 900 cycles needed
   always @(posedge clk_i)
   begin
      cycles = cycles + 1;
      if (cycles == 20000)
      begin
         err_count = err_count + 1;
         wrap_up;
      end
   end
   initial
   begin
      irq_src_i <= $random(seed) & 32'hf0000000;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      // Reset image; vector read skipped as it changes state
      for (k = 0; k < 84; k = k + 1)
         if (k < 72 && k != 64 || k > 76 && k != 80 && k != 81)
            rd(12'(k * 4), k == 67 ? irq_src_i : 32'h0);
      $display("test reset done");
      for (k = 0; k < 32; k = k + 1)
      begin
         m = $random(seed);
         hv[k] = $random(seed);
         wr(12'(k * 4), m);
         wr(12'(k * 4 + 128), hv[k]);
         rd(12'(k * 4), m & 32'h67);
         rd(12'(k * 4 + 128), hv[k]);
      end
      $display("test registers done");
      spur = $random(seed);
      wr(12'h134, spur);
      rd(12'h100, spur);
      wr(12'h130, spur);
      rd(12'h104, spur);
      $display("test spurious done");
      wr(12'h014, 32'h3);
      wr(12'h120, 32'h20);
      drive(32'h20);
      chk("normal line", 32'h0, {31'h0, normal_irq_n});
      rd(12'h100, hv[5]);
      stk.push_back(5);
      rd(12'h108, stk[$]);
      settle;
      chk("normal line", 32'h1, {31'h0, normal_irq_n});
      wr(12'h130, $random(seed));
      void'(stk.pop_back());
      settle;
      chk("normal line", stk.size() != 0, {31'h0, normal_irq_n});
      $display("test vector done");
      wr(12'h000, 32'h0);
      wr(12'h120, 32'h1);
      wr(12'h138, 32'h2);
      drive(32'h21);
      chk("masked lines", 32'h3, {30'h0, fast_irq_n, normal_irq_n});
      chk("wake", 32'h1, {31'h0, wake});
      wr(12'h138, 32'h0);
      settle;
      chk("lines", 32'h0, {30'h0, fast_irq_n, normal_irq_n});
      rd(12'h104, hv[0]);
      $display("test mask done");
      wr(12'h118, $random(seed));
      wr(12'h13c, $random(seed));
      i_core_model.xfer(1'b1, 32'h00000134, 32'h0, v);
      i_core_model.xfer(1'b0, 32'h00000134, 32'h0, v);
      chk("outside read", 32'h0, v);
      rd(12'h134, spur);
      $display("test reserved done");
      wrap_up;
   end
endmodule // tb_top
